// [pkg/wdog_pkg.sv]
//------------------------------------------------------------
// watchdog status and safe output constants
//------------------------------------------------------------
package wdog_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] GLOBAL_OFFSET = 8'h08;
    localparam logic [7:0] SAFE_BASE_OFFSET = 8'h40;

    // field positions of the control, status and global words
    localparam int ENABLE_BIT = 28;
    localparam int SAFE_EN_BIT = 25;
    localparam int IRQ_BIT = 24;
    localparam int EXPIRED_BIT = 20;
    localparam int TICK_LSB = 16;
    localparam int COUNT_W = 16;
    localparam int ACK_MODE_BIT = 0;

    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] SAFE_RESET = 8'h00;
    localparam logic GLOBAL_RESET = 1'b0;

    // acknowledge modes of the global control word
    localparam logic ACK_ON_READ = 1'b0;
    localparam logic ACK_ON_WRITE = 1'b1;

    // tick period codes
    localparam logic [1:0] TICK_100NS = 2'h0;
    localparam logic [1:0] TICK_1US = 2'h1;
    localparam logic [1:0] TICK_1MS = 2'h2;
    localparam logic [1:0] TICK_60NS = 2'h3;

    // tick periods and their cycle counts at the system clock
    localparam int CLK_FREQ_MHZ = 50;
    localparam int T_100NS_NS = 100;
    localparam int T_1US_NS = 1000;
    localparam int T_1MS_NS = 1000000;
    localparam int T_60NS_NS = 60;
    localparam int CYC_100NS = T_100NS_NS * CLK_FREQ_MHZ / 1000;
    localparam int CYC_1US = T_1US_NS * CLK_FREQ_MHZ / 1000;
    localparam int CYC_1MS = T_1MS_NS * CLK_FREQ_MHZ / 1000;
    localparam int CYC_60NS = T_60NS_NS * CLK_FREQ_MHZ / 1000;

endpackage

// [hdl/wdog_safe_outputs.sv]
module wdog_safe_outputs #(
    parameter int NUM_PORTS = 16,
    parameter bit REDUCED_PORTS = 1'b0,
    parameter int MS_TICK_CYCLES = wdog_pkg::CYC_1MS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port data path
    input wire logic [NUM_PORTS*8-1:0] port_out_data,
    output logic [NUM_PORTS*8-1:0] port_out,
    // expiry interrupt request
    output logic expiry_irq
);
    import wdog_pkg::*;

    //------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------
    if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_bad_ports
        $error("NUM_PORTS must lie between 1 and 16");
    end
    if (MS_TICK_CYCLES < 1 || MS_TICK_CYCLES > 65536) begin : g_bad_ms
        $error("MS_TICK_CYCLES must lie between 1 and 65536");
    end

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    logic countdown_enable_q;
    logic safe_output_enable_q;
    logic expiry_irq_enable_q;
    logic [1:0] tick_period_select_q;
    logic [COUNT_W-1:0] countdown_start_value_q;
    logic irq_acknowledge_mode_q;
    logic [7:0] safe_output_register_q [NUM_PORTS];
    logic [COUNT_W-1:0] remaining_count_q;
    logic expired_indicator_q;
    logic expiry_irq_pending_q;
    logic enable_prev_q;
    logic [15:0] div_q;
    logic [31:0] prdata_q;
    logic [NUM_PORTS*8-1:0] port_out_q;

    logic setup_rd;
    logic access_done;
    logic hit_ctrl;
    logic hit_status;
    logic hit_global;
    logic hit_safe;
    logic [3:0] safe_idx;
    logic addr_hit;
    logic status_access;
    logic reload;
    logic tick;
    logic expiry_evt;
    logic ack_clear;
    logic takeover;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic [31:0] read_mux;

    //------------------------------------------------------------
    // helper functions
    //------------------------------------------------------------
    // last divider value for a tick period code
    function automatic logic [15:0] tick_limit(input logic [1:0] code);
        logic [15:0] lim;
        lim = 16'(CYC_100NS - 1);
        if (code == TICK_1US) begin
            lim = 16'(CYC_1US - 1);
        end else if (code == TICK_1MS) begin
            lim = 16'(MS_TICK_CYCLES - 1);
        end else if (code == TICK_60NS) begin
            lim = 16'(CYC_60NS - 1);
        end
        return lim;
    endfunction

    // port 15 on the reduced build carries no register
    function automatic logic port_live(input int idx);
        return !(REDUCED_PORTS && idx == 15);
    endfunction

    //------------------------------------------------------------
    // apb decode and handshake
    //------------------------------------------------------------
    // address decode
    always_comb begin
        hit_ctrl = 1'b0;
        hit_status = 1'b0;
        hit_global = 1'b0;
        hit_safe = 1'b0;
        safe_idx = paddr[5:2];
        if (paddr == CTRL_OFFSET) begin
            hit_ctrl = 1'b1;
        end else if (paddr == STATUS_OFFSET) begin
            hit_status = 1'b1;
        end else if (paddr == GLOBAL_OFFSET) begin
            hit_global = 1'b1;
        end else if (paddr[7:6] == SAFE_BASE_OFFSET[7:6] &&
                     paddr[1:0] == 2'h0 &&
                     int'(paddr[5:2]) < NUM_PORTS) begin
            hit_safe = 1'b1;
        end
    end

    // no wait states: data is registered in the setup cycle
    assign addr_hit = hit_ctrl | hit_status | hit_global | hit_safe;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_hit;
    assign access_done = psel & penable & addr_hit;
    assign prdata = prdata_q;

    //------------------------------------------------------------
    // register words
    //------------------------------------------------------------
    // status word assembly, reserved bits left at zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ENABLE_BIT] = countdown_enable_q;
        status_word[SAFE_EN_BIT] = safe_output_enable_q;
        status_word[IRQ_BIT] = expiry_irq_pending_q;
        status_word[EXPIRED_BIT] = expired_indicator_q;
        status_word[TICK_LSB+1:TICK_LSB] =
            tick_period_select_q;
        status_word[COUNT_W-1:0] = remaining_count_q;
    end

    // control word readback
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[ENABLE_BIT] = countdown_enable_q;
        ctrl_word[SAFE_EN_BIT] = safe_output_enable_q;
        ctrl_word[IRQ_BIT] = expiry_irq_enable_q;
        ctrl_word[TICK_LSB+1:TICK_LSB] = tick_period_select_q;
        ctrl_word[COUNT_W-1:0] = countdown_start_value_q;
    end

    // read multiplexer, unmapped reads return zero
    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            read_mux = ctrl_word;
        end else if (hit_status) begin
            read_mux = status_word;
        end else if (hit_global) begin
            read_mux[ACK_MODE_BIT] = irq_acknowledge_mode_q;
        end else if (hit_safe && port_live(int'(safe_idx))) begin
            read_mux[7:0] = safe_output_register_q[safe_idx];
        end
    end

    // read data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_q <= read_mux;
        end
    end

    // control word
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            countdown_enable_q <= CTRL_RESET[ENABLE_BIT];
            safe_output_enable_q <= CTRL_RESET[SAFE_EN_BIT];
            expiry_irq_enable_q <= CTRL_RESET[IRQ_BIT];
            tick_period_select_q <= CTRL_RESET[TICK_LSB+1:TICK_LSB];
            countdown_start_value_q <= CTRL_RESET[COUNT_W-1:0];
        end else if (access_done && pwrite && hit_ctrl) begin
            countdown_enable_q <= pwdata[ENABLE_BIT];
            safe_output_enable_q <= pwdata[SAFE_EN_BIT];
            expiry_irq_enable_q <= pwdata[IRQ_BIT];
            tick_period_select_q <= pwdata[TICK_LSB+1:TICK_LSB];
            countdown_start_value_q <= pwdata[COUNT_W-1:0];
        end
    end

    // global control word: acknowledge mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_acknowledge_mode_q <= GLOBAL_RESET;
        end else if (access_done && pwrite && hit_global) begin
            irq_acknowledge_mode_q <= pwdata[ACK_MODE_BIT];
        end
    end

    // safe output registers, writable at any time
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                safe_output_register_q[i] <= SAFE_RESET;
            end
        end else if (access_done && pwrite && hit_safe &&
                     port_live(int'(safe_idx))) begin
            safe_output_register_q[safe_idx] <= pwdata[7:0];
        end
    end

    //------------------------------------------------------------
    // countdown
    //------------------------------------------------------------
    // retrigger on any status access, read or write
    assign status_access = access_done & hit_status;
    assign reload = status_access | (countdown_enable_q & ~enable_prev_q);

    // enable edge tracker
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= countdown_enable_q;
        end
    end

    // tick divider, restarted with every reload
    assign tick = countdown_enable_q & ~reload &
                  (div_q >= tick_limit(tick_period_select_q));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 16'h0000;
        end else if (!countdown_enable_q || reload || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // remaining count
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            remaining_count_q <= '0;
        end else if (reload) begin
            remaining_count_q <= countdown_start_value_q;
        end else if (tick && remaining_count_q != '0) begin
            remaining_count_q <= remaining_count_q - 1'b1;
        end
    end

    // expiry when the enabled count stands at zero
    assign expiry_evt = countdown_enable_q & ~reload & ~expired_indicator_q &
                        (remaining_count_q == '0);

    // expired flag, cleared by retrigger or disable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            expired_indicator_q <= 1'b0;
        end else if (expiry_evt) begin
            expired_indicator_q <= 1'b1;
        end else if (reload || !countdown_enable_q) begin
            expired_indicator_q <= 1'b0;
        end
    end

    // acknowledge per selected mode
    assign ack_clear = status_access &
        ((irq_acknowledge_mode_q == ACK_ON_READ && !pwrite) ||
         (irq_acknowledge_mode_q == ACK_ON_WRITE && pwrite &&
          pwdata[IRQ_BIT]));

    // pending interrupt, a new expiry wins over a clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            expiry_irq_pending_q <= 1'b0;
        end else if (expiry_evt && expiry_irq_enable_q) begin
            expiry_irq_pending_q <= 1'b1;
        end else if (ack_clear) begin
            expiry_irq_pending_q <= 1'b0;
        end
    end

    assign expiry_irq = expiry_irq_pending_q;

    //------------------------------------------------------------
    // output takeover
    //------------------------------------------------------------
    assign takeover = expired_indicator_q & safe_output_enable_q;

    // registered port outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            port_out_q <= '0;
        end else begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (takeover && port_live(i)) begin
                    port_out_q[i*8 +: 8] <= safe_output_register_q[i];
                end else begin
                    port_out_q[i*8 +: 8] <= port_out_data[i*8 +: 8];
                end
            end
        end
    end

    assign port_out = port_out_q;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence status_read_s;
        psel && penable && !pwrite && paddr == STATUS_OFFSET;
    endsequence

    sequence status_any_s;
        psel && penable && paddr == STATUS_OFFSET;
    endsequence

    a_retrigger_reload: assert property (
        status_any_s |=> remaining_count_q == $past(countdown_start_value_q))
        else $error("status access did not reload count");

    a_status_enable_bit: assert property (
        status_read_s |-> prdata[ENABLE_BIT] == $past(countdown_enable_q))
        else $error("enable bit wrong in status word");

    a_status_safe_bit: assert property (
        status_read_s |-> prdata[SAFE_EN_BIT] == $past(safe_output_enable_q))
        else $error("safe output bit wrong in status word");

    a_status_irq_bit: assert property (
        status_read_s |-> prdata[IRQ_BIT] == $past(expiry_irq_pending_q))
        else $error("pending bit wrong in status word");

    a_read_ack_clear: assert property (
        status_read_s ##0 (irq_acknowledge_mode_q == ACK_ON_READ &&
        !expiry_evt) |=> !expiry_irq_pending_q)
        else $error("read acknowledge left interrupt pending");

    a_status_expired_bit: assert property (
        status_read_s |-> prdata[EXPIRED_BIT] == $past(expired_indicator_q))
        else $error("expired bit wrong in status word");

    a_status_tick_field: assert property (
        status_read_s |-> prdata[17:16] == $past(tick_period_select_q))
        else $error("tick field wrong in status word");

    a_tick_60ns_gap: assert property (
        tick && tick_period_select_q == TICK_60NS |=> !tick ##1 !tick)
        else $error("60ns tick came too soon");

    a_status_count_field: assert property (
        status_read_s |-> prdata[15:0] == $past(remaining_count_q))
        else $error("count field wrong in status word");

    a_status_reserved: assert property (
        status_read_s |-> (prdata & 32'hECEC_0000) == 32'h0000_0000)
        else $error("reserved status bits not zero");

    a_safe_takeover: assert property (
        takeover && port_live(0) |=>
        port_out[7:0] == $past(safe_output_register_q[0]))
        else $error("port 0 not driven from safe register");

    a_expiry_flags: assert property (
        expiry_evt |=> expired_indicator_q &&
        (expiry_irq_pending_q || !$past(expiry_irq_enable_q)))
        else $error("expiry did not set its flags");

endmodule // wdog_safe_outputs

// [dv/watchdog_status_safe_outputs_test.sv]
module watchdog_status_safe_outputs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import wdog_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int MS_TICKS = 10;
    localparam logic [127:0] NORMAL =
        128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, expiry_irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [127:0] port_out_data, port_out, safe_vec;
    logic err;
    int n_mismatch, checks;
    int per_tab[4] = '{CYC_100NS, CYC_1US, MS_TICKS, CYC_60NS};

    // short millisecond tick keeps the run brief
    wdog_safe_outputs #(.MS_TICK_CYCLES(MS_TICKS)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_out_data(port_out_data),
        .port_out(port_out), .expiry_irq(expiry_irq));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [127:0] seen,
                         input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic range_chk(input string name, input int lo, input int hi);
        check(name, (rd[15:0] >= lo && rd[15:0] <= hi), 1'b1);
    endtask

    task automatic close_out();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check("status reset", rd, 32'h0);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, SAFE_BASE_OFFSET + 8'(4 * i), 32'h0);
            check("safe reset", rd, 32'h0);
        end
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        check("irq idle", expiry_irq, 1'b0);
        check("normal drive", port_out, port_out_data);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, SAFE_BASE_OFFSET + 8'(4 * i),
                {24'h0, 4'(i), 4'(15 - i)});
            safe_vec[8*i +: 8] = {4'(i), 4'(15 - i)};
        end
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, SAFE_BASE_OFFSET + 8'(4 * i), 32'h0);
            check("safe rw", rd, {24'h0, 4'(i), 4'(15 - i)});
        end
        apb(1'b1, CTRL_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        check("ctrl fields", rd, 32'h1303_FFFF);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check("status hi", rd[31:16], 16'h1203);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        check("status off", rd[31:16], 16'h0);
    endtask

    // each tick code counts down at its own period; accesses reload
    task automatic t_ticks();
        int k;
        for (int c = 0; c < 4; c++) begin
            k = 20 * per_tab[c];
            apb(1'b1, CTRL_OFFSET, {3'h0, 1'b1, 10'h0, 2'(c), 16'd1000});
            apb(1'b0, STATUS_OFFSET, 32'h0);
            repeat (k) @(posedge ref_clk);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            check("tick hi", rd[31:16], 16'h1000 | 16'(c));
            range_chk("tick count", 978, 981);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            range_chk("read reload", 998, 1000);
            repeat (k) @(posedge ref_clk);
            apb(1'b1, STATUS_OFFSET, 32'h0);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            range_chk("write reload", 998, 1000);
        end
        apb(1'b1, CTRL_OFFSET, 32'h0);
    endtask

    // expiry with or without takeover, in either acknowledge mode
    task automatic t_expiry(input logic safe, input logic mode);
        int n;
        logic [31:0] exp_st;
        apb(1'b1, GLOBAL_OFFSET, {31'h0, mode});
        port_out_data <= ~NORMAL;
        apb(1'b1, CTRL_OFFSET,
            {3'h0, 1'b1, 2'h0, safe, 1'b1, 6'h0, 2'h3, 16'd30});
        n = 0;
        while (expiry_irq !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("irq raised", expiry_irq, 1'b1);
        repeat (3) @(posedge ref_clk);
        #1;
        check("takeover", port_out, safe ? safe_vec : ~NORMAL);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        // enabled, safe use, pending, expired, 60ns code, count at zero
        exp_st = {3'h0, 1'b1, 2'h0, safe, 1'b1, 3'h0, 1'b1, 4'h3, 16'h0};
        check("status expired", rd, exp_st);
        @(posedge ref_clk);
        #1;
        check("read ack", expiry_irq, mode);
        check("release", port_out, ~NORMAL);
        if (mode) begin
            apb(1'b1, STATUS_OFFSET, 32'h0100_0000);
            @(posedge ref_clk);
            #1;
            check("write ack", expiry_irq, 1'b0);
        end
        apb(1'b1, CTRL_OFFSET, 32'h0);
        apb(1'b1, GLOBAL_OFFSET, 32'h0);
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        port_out_data = NORMAL;
        safe_vec = '0;
        n_mismatch = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_regs();
        t_ticks();
        t_expiry(1'b1, ACK_ON_READ);
        t_expiry(1'b0, ACK_ON_WRITE);
        close_out();
    end

    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end

endmodule // watchdog_status_safe_outputs_test
